// [hw/tsic_regs.svh]
// Register offsets, field positions and constants of the timer control block
`ifndef TSIC_REGS_SVH
`define TSIC_REGS_SVH

`define TSIC_ADDR_WCNT 32'h700c501c
`define TSIC_ADDR_FLAGS 32'h700c5024
`define TSIC_ADDR_MASK 32'h700c5028
`define TSIC_ADDR_SETUP 32'h700c502c
`define TSIC_ADDR_IPRE 32'h700c5050
`define TSIC_ADDR_WPRE 32'h700c5054

`define TSIC_INTV_LSB 0
`define TSIC_INTV_MSB 3
`define TSIC_PWM_LSB 8
`define TSIC_PWM_MSB 10
`define TSIC_WDOG_BIT 11

`define TSIC_RUN_LSB 11
`define TSIC_RUN_MSB 14
`define TSIC_PWM1_RUN_BIT 0
`define TSIC_PWM2_RUN_BIT 1
`define TSIC_PWM3_RUN_BIT 9
`define TSIC_IRQ_MODE_BIT 8
`define TSIC_CLK_SEL_BIT 5
`define TSIC_SCOPE_BIT 4
`define TSIC_ARM_BIT 3

`define TSIC_UNLOCK 16'hfade
`define TSIC_WCNT_TOP 16'hfffe
`define TSIC_WCNT_RESET 16'h0000
`define TSIC_PRE_RESET 12'h000
`define TSIC_RATE_MAX 4'hb
`define TSIC_PRE_ONE 12'h001

`endif

// [hw/tsic_pkg.sv]
// Types shared by the timer control block
package tsic_pkg;
  typedef logic [11:0] tsic_pre_t;
  typedef logic [15:0] tsic_wcnt_t;
  typedef logic [3:0] tsic_rate_t;
endpackage

// [hw/tsic_top.sv]
// Timer status, interrupt, run enables and watchdog control
`timescale 1ns/1ps
`include "tsic_regs.svh"

module tsic_top (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Peripheral bus
  input wire logic bus_sel_i,
  input wire logic bus_write_i,
  input wire logic [31:0] bus_addr_i,
  input wire logic [31:0] bus_wdata_i,
  output logic [31:0] bus_rdata_o,
  // Channel events
  input wire logic [3:0] intv_event_i,
  input wire logic [2:0] pwm_event_i,
  // Prescaler rate codes
  input wire tsic_pkg::tsic_rate_t intv_rate_i,
  input wire tsic_pkg::tsic_rate_t wdog_rate_i,
  // Slow clock pin
  input wire logic slow_clk_i,
  // Outputs
  output logic timer_irq_o,
  output logic wdog_reset_o,
  output logic intv_tick_o,
  output logic [3:0] interval_run_o,
  output logic [2:0] pwm_run_o
);

  logic [3:0] intv_flag;
  logic [2:0] pwm_flag;
  logic wdog_status_flag;
  logic [11:0] timer_irq_mask;
  logic wdog_irq_mode;
  logic wdog_clock_select;
  logic wdog_reset_scope;
  logic wdog_run_arm;
  tsic_pkg::tsic_wcnt_t wdog_count;
  tsic_pkg::tsic_pre_t intv_pre;
  tsic_pkg::tsic_pre_t wdog_pre;
  logic slow_sync1;
  logic slow_sync2;
  logic slow_sync3;

  logic wr;
  logic rd;
  logic wr_flags;
  logic wr_setup;
  logic wr_wcnt;
  logic unlock;
  logic wd_regs_rst;
  logic wd_step;
  logic wd_tick;
  logic wd_timeout;
  logic intv_any_run;
  logic [11:0] flags_word;
  logic [11:0] next_irq_src;

  function automatic logic reg_hit(input logic [31:0] a,
                                   input logic [31:0] off);
    reg_hit = (a == off);
  endfunction

  // Reserved codes fall back to the longest divisor
  function automatic logic pre_due(input tsic_pkg::tsic_pre_t cnt,
                                   input tsic_pkg::tsic_rate_t code);
    tsic_pkg::tsic_rate_t c;
    tsic_pkg::tsic_pre_t m;
    c = (code > `TSIC_RATE_MAX) ? `TSIC_RATE_MAX : code;
    m = tsic_pkg::tsic_pre_t'((`TSIC_PRE_ONE << (c + 4'h1)) - `TSIC_PRE_ONE);
    pre_due = ((cnt & m) == m);
  endfunction

  assign wr = bus_sel_i && bus_write_i;
  assign rd = bus_sel_i && !bus_write_i;
  assign wr_flags = wr && reg_hit(bus_addr_i, `TSIC_ADDR_FLAGS);
  assign wr_setup = wr && reg_hit(bus_addr_i, `TSIC_ADDR_SETUP);
  assign wr_wcnt = wr && reg_hit(bus_addr_i, `TSIC_ADDR_WCNT);
  assign unlock = wr_wcnt && (bus_wdata_i[15:0] == `TSIC_UNLOCK);
  assign intv_any_run = |interval_run_o;
  // Own watchdog reset always clears; external only when scope is zero
  assign wd_regs_rst = wdog_reset_o || (reset_i && !wdog_reset_scope);
  // Slow clock acts on its synchronised rising edge only
  assign wd_step = wdog_clock_select ? (slow_sync2 && !slow_sync3)
                                     : 1'b1;
  assign wd_tick = wdog_run_arm && wd_step && pre_due(wdog_pre, wdog_rate_i);
  assign wd_timeout = wd_tick && (wdog_count == `TSIC_WCNT_TOP);
  assign flags_word = {wdog_status_flag, pwm_flag, 4'h0, intv_flag};
  assign next_irq_src = flags_word & timer_irq_mask;

  // Slow clock synchroniser
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      slow_sync1 <= slow_clk_i;
      slow_sync2 <= slow_sync1;
      slow_sync3 <= slow_sync2;
    end
  end

  // Interval and pulse status flags; a same-cycle event beats the clear
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      intv_flag <= 4'h0;
      pwm_flag <= 3'h0;
    end else if (ce_i) begin
      intv_flag <= (intv_flag & ~(wr_flags ?
        bus_wdata_i[`TSIC_INTV_MSB:`TSIC_INTV_LSB] : 4'h0))
        | intv_event_i;
      pwm_flag <= (pwm_flag & ~(wr_flags ?
        bus_wdata_i[`TSIC_PWM_MSB:`TSIC_PWM_LSB] : 3'h0))
        | pwm_event_i;
    end
  end

  // Interrupt enables and run bits
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      timer_irq_mask <= 12'h000;
      interval_run_o <= 4'h0;
      pwm_run_o <= 3'h0;
    end else if (ce_i) begin
      if (wr && reg_hit(bus_addr_i, `TSIC_ADDR_MASK)) begin
        timer_irq_mask <= bus_wdata_i[11:0] & 12'hf0f;
      end
      if (wr_setup) begin
        interval_run_o <= bus_wdata_i[`TSIC_RUN_MSB:`TSIC_RUN_LSB];
        pwm_run_o <= {bus_wdata_i[`TSIC_PWM3_RUN_BIT],
                      bus_wdata_i[`TSIC_PWM2_RUN_BIT],
                      bus_wdata_i[`TSIC_PWM1_RUN_BIT]};
      end
    end
  end

  // Interrupt request
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      timer_irq_o <= 1'b0;
    end else if (ce_i) begin
      timer_irq_o <= |next_irq_src;
    end
  end

  // Clock select and scope: external reset only, locked while armed
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wdog_clock_select <= 1'b0;
      wdog_reset_scope <= 1'b0;
    end else if (ce_i && wr_setup && !wdog_run_arm) begin
      wdog_clock_select <= bus_wdata_i[`TSIC_CLK_SEL_BIT];
      wdog_reset_scope <= bus_wdata_i[`TSIC_SCOPE_BIT];
    end
  end

  // Enable is sticky until reset; mode locks with it
  always_ff @(posedge clk_i) begin
    if (wd_regs_rst) begin
      wdog_run_arm <= 1'b0;
      wdog_irq_mode <= 1'b0;
    end else if (ce_i && wr_setup && !wdog_run_arm) begin
      wdog_run_arm <= bus_wdata_i[`TSIC_ARM_BIT];
      wdog_irq_mode <= bus_wdata_i[`TSIC_IRQ_MODE_BIT];
    end
  end

  // Watchdog count
  always_ff @(posedge clk_i) begin
    if (wd_regs_rst) begin
      wdog_count <= `TSIC_WCNT_RESET;
    end else if (ce_i) begin
      if (unlock) begin
        wdog_count <= `TSIC_WCNT_RESET;
      end else if (wr_wcnt && !wdog_run_arm) begin
        wdog_count <= bus_wdata_i[15:0];
      end else if (wd_tick) begin
        wdog_count <= wdog_count + 16'h0001;
      end
    end
  end

  // Watchdog flag and reset pulse; a timeout beats the unlock clear
  always_ff @(posedge clk_i) begin
    if (wd_regs_rst) begin
      wdog_status_flag <= 1'b0;
      wdog_reset_o <= 1'b0;
    end else if (ce_i) begin
      wdog_reset_o <= wd_timeout &&
                      (!wdog_irq_mode || wdog_status_flag);
      if (wd_timeout && wdog_irq_mode) begin
        wdog_status_flag <= 1'b1;
      end else if (unlock) begin
        wdog_status_flag <= 1'b0;
      end
    end
  end

  // Interval prescaler runs only while a channel runs
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      intv_pre <= `TSIC_PRE_RESET;
      intv_tick_o <= 1'b0;
    end else if (ce_i) begin
      intv_tick_o <= intv_any_run && pre_due(intv_pre, intv_rate_i);
      if (wr && reg_hit(bus_addr_i, `TSIC_ADDR_IPRE)) begin
        if (!intv_any_run) begin
          intv_pre <= bus_wdata_i[11:0];
        end
      end else if (intv_any_run) begin
        intv_pre <= intv_pre + `TSIC_PRE_ONE;
      end
    end
  end

  // Watchdog prescaler
  always_ff @(posedge clk_i) begin
    if (wd_regs_rst) begin
      wdog_pre <= `TSIC_PRE_RESET;
    end else if (ce_i) begin
      if (wr && reg_hit(bus_addr_i, `TSIC_ADDR_WPRE)) begin
        if (!wdog_run_arm) begin
          wdog_pre <= bus_wdata_i[11:0];
        end
      end else if (wdog_run_arm && wd_step) begin
        wdog_pre <= wdog_pre + `TSIC_PRE_ONE;
      end
    end
  end

  // Read data one cycle after the read; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bus_rdata_o <= 32'h0000_0000;
    end else if (ce_i && rd) begin
      if (reg_hit(bus_addr_i, `TSIC_ADDR_FLAGS)) begin
        bus_rdata_o <= {20'h0_0000, flags_word};
      end else if (reg_hit(bus_addr_i, `TSIC_ADDR_MASK)) begin
        bus_rdata_o <= {20'h0_0000, timer_irq_mask};
      end else if (reg_hit(bus_addr_i, `TSIC_ADDR_SETUP)) begin
        bus_rdata_o <= {17'h0_0000, interval_run_o, 1'b0, pwm_run_o[2],
                        wdog_irq_mode, 2'h0, wdog_clock_select,
                        wdog_reset_scope, wdog_run_arm, 1'b0,
                        pwm_run_o[1:0]};
      end else if (reg_hit(bus_addr_i, `TSIC_ADDR_WCNT)) begin
        bus_rdata_o <= {16'h0000, wdog_count};
      end else if (reg_hit(bus_addr_i, `TSIC_ADDR_IPRE)) begin
        bus_rdata_o <= {20'h0_0000, intv_pre};
      end else if (reg_hit(bus_addr_i, `TSIC_ADDR_WPRE)) begin
        bus_rdata_o <= {20'h0_0000, wdog_pre};
      end else begin
        bus_rdata_o <= 32'h0000_0000;
      end
    end
  end

  // Checks
  sequence s_flag_rises;
    ##1 wdog_status_flag && !wdog_reset_o;
  endsequence

  sequence s_reset_fires;
    ##1 wdog_reset_o;
  endsequence

  property p_intv_set;
    @(posedge clk_i) disable iff (reset_i)
      ce_i |=> ((intv_flag & $past(intv_event_i)) == $past(intv_event_i));
  endproperty
  a_intv_set: assert property (p_intv_set) else $error("interval flag lost");

  property p_pwm_set;
    @(posedge clk_i) disable iff (reset_i)
      ce_i |=> ((pwm_flag & $past(pwm_event_i)) == $past(pwm_event_i));
  endproperty
  a_pwm_set: assert property (p_pwm_set) else $error("pulse flag lost");

  property p_flag_clear;
    @(posedge clk_i) disable iff (reset_i)
      ce_i && wr_flags && bus_wdata_i[0] && !intv_event_i[0]
        |=> !intv_flag[0];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("no clear");

  property p_wdog_flag_keep;
    @(posedge clk_i) disable iff (reset_i)
      ce_i && wr_flags && wdog_status_flag && !unlock && !wdog_reset_o
        |=> wdog_status_flag;
  endproperty
  a_wdog_flag_keep: assert property (p_wdog_flag_keep)
    else $error("watchdog flag cleared by status write");

  property p_unlock;
    @(posedge clk_i) disable iff (reset_i || wdog_reset_o)
      ce_i && unlock |=> wdog_count == `TSIC_WCNT_RESET;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock ignored");

  property p_irq;
    @(posedge clk_i) disable iff (reset_i)
      ce_i |=> timer_irq_o == $past(|next_irq_src);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_timeout_flag;
    @(posedge clk_i) disable iff (reset_i || wdog_reset_o)
      ce_i && wd_timeout && wdog_irq_mode && !wdog_status_flag
        |-> s_flag_rises;
  endproperty
  a_timeout_flag: assert property (p_timeout_flag)
    else $error("timeout did not set flag");

  property p_timeout_reset;
    @(posedge clk_i) disable iff (reset_i || wdog_reset_o)
      ce_i && wd_timeout && !wdog_irq_mode |-> s_reset_fires;
  endproperty
  a_timeout_reset: assert property (p_timeout_reset)
    else $error("timeout did not reset");

  property p_lock;
    @(posedge clk_i) disable iff (reset_i)
      wdog_run_arm && !wdog_reset_o |=>
        $stable(wdog_clock_select) && $stable(wdog_reset_scope);
  endproperty
  a_lock: assert property (p_lock) else $error("locked bit changed");

endmodule

// [verif/tsic_top_tb.sv]
// Self-checking bench for the timer status and watchdog control block
`timescale 1ns/1ps
`include "tsic_regs.svh"
`define CHK(got, exp) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, got, exp); \
  end \
end
module tsic_top_tb;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ce_i = 1'b1;
  logic bus_sel_i = 1'b0;
  logic bus_write_i = 1'b0;
  logic [31:0] bus_addr_i = 32'h0;
  logic [31:0] bus_wdata_i = 32'h0;
  logic [31:0] bus_rdata_o;
  logic [3:0] intv_event_i = 4'h0;
  logic [2:0] pwm_event_i = 3'h0;
  tsic_pkg::tsic_rate_t intv_rate_i = 4'h0;
  tsic_pkg::tsic_rate_t wdog_rate_i = 4'h0;
  logic slow_clk_i = 1'b0;
  logic timer_irq_o;
  logic wdog_reset_o;
  logic intv_tick_o;
  logic [3:0] interval_run_o;
  logic [2:0] pwm_run_o;
  int n_errors = 0;
  int n_compared = 0;
  int mflags, mmask, ticks, k, e, nres;
  int q[$] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 15};
  logic [31:0] rd, v, cl;
  logic [6:0] ev;

  tsic_top u_tsic_top (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
    .bus_sel_i(bus_sel_i), .bus_write_i(bus_write_i),
    .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i),
    .bus_rdata_o(bus_rdata_o), .intv_event_i(intv_event_i),
    .pwm_event_i(pwm_event_i), .intv_rate_i(intv_rate_i),
    .wdog_rate_i(wdog_rate_i), .slow_clk_i(slow_clk_i),
    .timer_irq_o(timer_irq_o), .wdog_reset_o(wdog_reset_o),
    .intv_tick_o(intv_tick_o), .interval_run_o(interval_run_o),
    .pwm_run_o(pwm_run_o));

  always #12.5 clk_i = ~clk_i;

  // Pulse counter, so a one-cycle reset pulse is never missed
  always @(posedge clk_i) begin
    if (wdog_reset_o === 1'b1) nres++;
  end

  task automatic acc(input logic w, input logic [31:0] a,
                     input logic [31:0] d, input logic [6:0] evs);
    @(posedge clk_i);
    #1;
    bus_sel_i = 1'b1;
    bus_write_i = w;
    bus_addr_i = a;
    bus_wdata_i = d;
    {pwm_event_i, intv_event_i} = evs;
    @(posedge clk_i);
    #1;
    bus_sel_i = 1'b0;
    {pwm_event_i, intv_event_i} = 7'h0;
    rd = bus_rdata_o;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    acc(1'b1, a, d, 7'h0);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0, 7'h0);
    `CHK(rd, exp)
  endtask

  // A short reset lets the scope bit act before it is cleared
  task automatic rst(input int cyc);
    reset_i = 1'b1;
    repeat (cyc) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    mflags = 0;
    mmask = 0;
  endtask

  task automatic print_verdict();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Watchdog on the run itself
  initial begin
    repeat (60000) @(posedge clk_i);
    n_errors++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'h961337ee));
    rst(20);
    rdc(`TSIC_ADDR_FLAGS, 32'h0);
    rdc(`TSIC_ADDR_MASK, 32'h0);
    rdc(`TSIC_ADDR_SETUP, 32'h0);
    rdc(32'h700c5020, 32'h0);
    wr(`TSIC_ADDR_MASK, 32'hffffffff);
    rdc(`TSIC_ADDR_MASK, 32'h00000f0f);
    // Random events against random clears, event wins a tie
    for (k = 0; k < 16; k++) begin
      mmask = $urandom & 32'h70f;
      wr(`TSIC_ADDR_MASK, mmask);
      cl = $urandom & 32'hf0f;
      ev = $urandom;
      acc(1'b1, `TSIC_ADDR_FLAGS, cl, ev);
      mflags = (mflags & ~(cl & 32'h70f)) | {ev[6:4], 4'h0, ev[3:0]};
      rdc(`TSIC_ADDR_FLAGS, mflags);
      `CHK(timer_irq_o, |(mflags & mmask))
    end
    for (k = 0; k < 6; k++) begin
      v = $urandom & 32'h7a03;
      wr(`TSIC_ADDR_SETUP, v);
      `CHK(interval_run_o, v[14:11])
      `CHK(pwm_run_o, {v[9], v[1], v[0]})
      rdc(`TSIC_ADDR_SETUP, v);
    end
    wr(`TSIC_ADDR_SETUP, 32'h0);
    wr(`TSIC_ADDR_IPRE, 32'hfffffa5a);
    rdc(`TSIC_ADDR_IPRE, 32'h00000a5a);
    wr(`TSIC_ADDR_WPRE, 32'h00000123);
    rdc(`TSIC_ADDR_WPRE, 32'h00000123);
    wr(`TSIC_ADDR_SETUP, 32'h800);
    wr(`TSIC_ADDR_IPRE, 32'h0);
    // One step before the refused write, one after it
    rdc(`TSIC_ADDR_IPRE, 32'h00000a5c);
    `CHK(rd[11:8], 4'ha)
    // Two whole periods hold exactly two ticks whatever the phase
    foreach (q[i]) begin
      intv_rate_i = q[i];
      e = (q[i] > 11) ? 11 : q[i];
      repeat (20) @(posedge clk_i);
      #1;
      ticks = 0;
      repeat (4 << e) begin
        @(posedge clk_i);
        #1;
        if (intv_tick_o === 1'b1) ticks++;
      end
      `CHK(ticks, 2)
    end
    // Interrupt mode: first timeout only raises the flag
    rst(20);
    nres = 0;
    wr(`TSIC_ADDR_MASK, 32'h800);
    wr(`TSIC_ADDR_WCNT, 32'hfffe);
    wr(`TSIC_ADDR_SETUP, 32'h108);
    k = 0;
    while (timer_irq_o !== 1'b1 && k < 40) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    `CHK(timer_irq_o, 1'b1)
    rdc(`TSIC_ADDR_FLAGS, 32'h800);
    `CHK(nres, 0)
    wr(`TSIC_ADDR_SETUP, 32'h030);
    rdc(`TSIC_ADDR_SETUP, 32'h108);
    wr(`TSIC_ADDR_FLAGS, 32'h800);
    rdc(`TSIC_ADDR_FLAGS, 32'h800);
    wr(`TSIC_ADDR_WCNT, {16'h0, `TSIC_UNLOCK});
    rdc(`TSIC_ADDR_FLAGS, 32'h0);
    `CHK(timer_irq_o, 1'b0)
    // Three prescaler steps since the unlock give one or two counts
    acc(1'b0, `TSIC_ADDR_WCNT, 32'h0, 7'h0);
    `CHK((rd == 32'h1) || (rd == 32'h2), 1'b1)
    `CHK(rd[31:2], 30'h0)
    // Reset mode: timeout resets at once, scope bit survives it
    rst(20);
    nres = 0;
    wr(`TSIC_ADDR_WCNT, 32'hfffe);
    wr(`TSIC_ADDR_SETUP, 32'h018);
    k = 0;
    while (nres == 0 && k < 40) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    `CHK(nres, 1)
    repeat (3) @(posedge clk_i);
    rdc(`TSIC_ADDR_FLAGS, 32'h0);
    rdc(`TSIC_ADDR_SETUP, 32'h010);
    // Scope set: external reset leaves the armed watchdog running
    wr(`TSIC_ADDR_WCNT, 32'h0);
    wr(`TSIC_ADDR_SETUP, 32'h018);
    rst(1);
    rdc(`TSIC_ADDR_SETUP, 32'h008);
    print_verdict();
  end
endmodule
